// >>> common/acp_pkg.sv
// Register map, field layout and types of the converter control block.
//==========================================================================
// Functional notes
// - Gain codes map to 1,4,8,16,32,64,512.
// - Voltage/temperature control register resets to zero.
// - Enable bit powers converter up.
// - Enable low powers down, clears ready flags.
// - Bypass field selects none, negative, positive, both.
// - Diagnostic field drives current into chosen inputs.
// - Channel field selects one of five inputs.
// - Reference bit selects internal or supply reference.
package acp_pkg;

  //========================================================================
  // Register byte addresses.
  localparam logic [31:0] ACP_VT_CTRL_ADDR  = 32'h4003_0010;
  localparam logic [31:0] ACP_CUR_CTRL_ADDR = 32'h4003_0040;
  localparam logic [31:0] ACP_READY_ADDR    = 32'h4003_0044;
  localparam logic [31:0] ACP_IRQ_STAT_ADDR = 32'h4003_0048;
  localparam logic [31:0] ACP_IRQ_MASK_ADDR = 32'h4003_004c;

  //========================================================================
  // Reset values and writable bit masks.
  localparam logic [31:0] ACP_VT_CTRL_RESET  = 32'h0000_0000;
  localparam logic [31:0] ACP_VT_CTRL_WMASK  = 32'h000b_33d0;
  localparam logic [31:0] ACP_CUR_CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] ACP_CUR_CTRL_WMASK = 32'h0000_000f;
  localparam logic [3:0]  ACP_IRQ_MASK_RESET = 4'h0;

  //========================================================================
  // Field positions.
  localparam int ACP_EN_BIT     = 19;
  localparam int ACP_BUFBP_LSB  = 16;
  localparam int ACP_DIAG_LSB   = 12;
  localparam int ACP_CODE_BIT   = 9;
  localparam int ACP_CH_LSB     = 6;
  localparam int ACP_REF_BIT    = 4;
  localparam int ACP_GAIN_LSB   = 0;
  localparam int ACP_RDY_V_BIT  = 0;
  localparam int ACP_RDY_T_BIT  = 1;
  localparam int ACP_RDY_EN_BIT = 2;

  //========================================================================
  // Gain codes and their base-two exponents.
  localparam logic [3:0] ACP_GAIN_1   = 4'h0;
  localparam logic [3:0] ACP_GAIN_4   = 4'h2;
  localparam logic [3:0] ACP_GAIN_8   = 4'h3;
  localparam logic [3:0] ACP_GAIN_16  = 4'h4;
  localparam logic [3:0] ACP_GAIN_32  = 4'h5;
  localparam logic [3:0] ACP_GAIN_64  = 4'h6;
  localparam logic [3:0] ACP_GAIN_512 = 4'h9;

  // Channel codes.
  localparam logic [2:0] ACP_CH_BATTERY  = 3'h0;
  localparam logic [2:0] ACP_CH_EXT_TEMP = 3'h1;
  localparam logic [2:0] ACP_CH_INT_TEMP = 3'h2;
  localparam logic [2:0] ACP_CH_AUX      = 3'h4;
  localparam logic [2:0] ACP_CH_DIAG     = 3'h6;

  //========================================================================
  // Interrupt events: voltage result, temperature result, bad gain code,
  // bad channel code.
  localparam int ACP_EV_W      = 4;
  localparam int ACP_EV_VOLT   = 0;
  localparam int ACP_EV_TEMP   = 1;
  localparam int ACP_EV_BAD_G  = 2;
  localparam int ACP_EV_BAD_CH = 3;

  typedef enum logic [1:0] {
    ACP_IDLE   = 2'b01,
    ACP_ACCESS = 2'b10
  } acp_apb_e;

  // Analog front end controls of the voltage/temperature converter.
  typedef struct packed {
    logic       enable;
    logic       power_down;
    logic       bypass_pos;
    logic       bypass_neg;
    logic       diag_pos;
    logic       diag_neg;
    logic       unipolar;
    logic [4:0] channel_onehot;
    logic       ref_supply;
  } acp_vt_fe_s;

  // Gain of the current converter as a power of two.
  typedef struct packed {
    logic [3:0] log2_gain;
    logic       reserved;
  } acp_gain_s;

endpackage

// >>> verilog/acp_apb_port.sv
// APB handshake sequencer with a registered ready.
`timescale 1ns/10ps
module acp_apb_port (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic pce,
  input  wire logic psel,
  input  wire logic penable,
  output logic      pready,
  output logic      setup,
  output logic      done
);
  import acp_pkg::*;

  acp_apb_e state;
  acp_apb_e next_state;

  // A setup cycle arms ready for the access phase, so no wait states.
  always_comb begin
    setup      = pce && psel && !penable && (state == ACP_IDLE);
    done       = pce && psel && penable && (state == ACP_ACCESS);
    next_state = state;
    unique case (state)
      ACP_IDLE:   if (setup) next_state = ACP_ACCESS;
      ACP_ACCESS: if (done) next_state = ACP_IDLE;
      default:    next_state = ACP_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state  <= ACP_IDLE;
      pready <= 1'b0;
    end else if (pce) begin
      state  <= next_state;
      pready <= (next_state == ACP_ACCESS);
    end
  end

endmodule

// >>> verilog/acp_sticky_bank.sv
// Sticky event flags with mask and a registered level interrupt.
`timescale 1ns/10ps
module acp_sticky_bank (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        pce,
  input  wire logic [acp_pkg::ACP_EV_W-1:0] set,
  input  wire logic [acp_pkg::ACP_EV_W-1:0] clr,
  input  wire logic [acp_pkg::ACP_EV_W-1:0] mask,
  output logic      [acp_pkg::ACP_EV_W-1:0] status,
  output logic                             irq
);
  import acp_pkg::*;

  logic [ACP_EV_W-1:0] next_status;

  // A set in the same cycle as a read clear wins, so no event is lost.
  for (genvar i = 0; i < ACP_EV_W; i++) begin : g_flag
    always_comb begin
      next_status[i] = set[i] | (status[i] & ~clr[i]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= '0;
      irq    <= 1'b0;
    end else if (pce) begin
      status <= next_status;
      irq    <= |(next_status & mask);
    end
  end

endmodule

// >>> verilog/acp_ctrl_regs.sv
// Control registers of the battery sensor measurement converters.
`timescale 1ns/10ps
module acp_ctrl_regs (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               pce,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [31:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               voltage_conv_done,
  input  wire logic               temp_conv_done,
  output acp_pkg::acp_vt_fe_s     vt_fe,
  output acp_pkg::acp_gain_s      current_gain_select,
  output logic                    voltage_result_ready,
  output logic                    temperature_result_ready,
  output logic                    irq
);
  import acp_pkg::*;

  //========================================================================
  // Bus handshake.
  // Zero wait states: pready rises in every access phase while pce is high.

  logic setup;
  logic done;

  acp_apb_port u_port (
    .pclk    (pclk),
    .presetn (presetn),
    .pce     (pce),
    .psel    (psel),
    .penable (penable),
    .pready  (pready),
    .setup   (setup),
    .done    (done)
  );

  //========================================================================
  // Address decode.

  logic hit_vt;
  logic hit_cur;
  logic hit_rdy;
  logic hit_stat;
  logic hit_mask;
  logic hit_any;

  // Full address compare; other addresses answer with an error.
  // A partial decode would be smaller, but its aliases would let stray
  // writes land in a control register.
  always_comb begin
    hit_vt   = (paddr == ACP_VT_CTRL_ADDR);
    hit_cur  = (paddr == ACP_CUR_CTRL_ADDR);
    hit_rdy  = (paddr == ACP_READY_ADDR);
    hit_stat = (paddr == ACP_IRQ_STAT_ADDR);
    hit_mask = (paddr == ACP_IRQ_MASK_ADDR);
    hit_any  = hit_vt | hit_cur | hit_rdy | hit_stat | hit_mask;
  end

  //========================================================================
  // Register storage.

  logic [31:0]         vt_ctrl;
  logic [31:0]         cur_ctrl;
  logic [ACP_EV_W-1:0] irq_mask;
  logic [31:0]         next_vt_ctrl;
  logic [31:0]         next_cur_ctrl;
  logic [ACP_EV_W-1:0] next_irq_mask;
  logic                wr_vt;
  logic                wr_cur;

  // Writes land only at the completing access edge. Masking on write
  // keeps reserved bits at zero, so readback needs no extra gating.
  // The current converter keeps only its gain field here.
  always_comb begin
    wr_vt         = done && pwrite && hit_vt;
    wr_cur        = done && pwrite && hit_cur;
    next_vt_ctrl  = vt_ctrl;
    next_cur_ctrl = cur_ctrl;
    next_irq_mask = irq_mask;
    if (wr_vt) begin
      next_vt_ctrl = pwdata & ACP_VT_CTRL_WMASK;
    end
    if (wr_cur) begin
      next_cur_ctrl = pwdata & ACP_CUR_CTRL_WMASK;
    end
    if (done && pwrite && hit_mask) begin
      next_irq_mask = pwdata[ACP_EV_W-1:0];
    end
  end

  // All registers freeze while pce is low, the bus handshake included.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vt_ctrl  <= ACP_VT_CTRL_RESET;
      cur_ctrl <= ACP_CUR_CTRL_RESET;
      irq_mask <= ACP_IRQ_MASK_RESET;
    end else if (pce) begin
      vt_ctrl  <= next_vt_ctrl;
      cur_ctrl <= next_cur_ctrl;
      irq_mask <= next_irq_mask;
    end
  end

  //========================================================================
  // Field extraction.

  logic       f_en;
  logic [1:0] f_bufbp;
  logic [1:0] f_diag;
  logic       f_code;
  logic [2:0] f_ch;
  logic       f_ref;
  logic [3:0] f_gain;

  // Fields are decoded from the next value so the front end follows
  // the register in the same edge that stores it. The cost is a longer
  // path from pwdata to the front end flops.
  always_comb begin
    f_en    = next_vt_ctrl[ACP_EN_BIT];
    f_bufbp = next_vt_ctrl[ACP_BUFBP_LSB +: 2];
    f_diag  = next_vt_ctrl[ACP_DIAG_LSB +: 2];
    f_code  = next_vt_ctrl[ACP_CODE_BIT];
    f_ch    = next_vt_ctrl[ACP_CH_LSB +: 3];
    f_ref   = next_vt_ctrl[ACP_REF_BIT];
    f_gain  = next_cur_ctrl[ACP_GAIN_LSB +: 4];
  end

  //========================================================================
  // Gain decode of the current converter.

  // Returns the exponent of two and a reserved flag. A reserved code
  // reports gain 1 so the front end never sees an undefined setting.
  function automatic acp_gain_s decode_gain(input logic [3:0] code);
    acp_gain_s g;
    g.reserved = 1'b0;
    g.log2_gain = 4'h0;
    // Listed codes happen to equal their exponent; the table stays
    // explicit so a changed code cannot silently shift a gain.
    unique case (code)
      ACP_GAIN_1:   g.log2_gain = 4'h0;
      ACP_GAIN_4:   g.log2_gain = 4'h2;
      ACP_GAIN_8:   g.log2_gain = 4'h3;
      ACP_GAIN_16:  g.log2_gain = 4'h4;
      ACP_GAIN_32:  g.log2_gain = 4'h5;
      ACP_GAIN_64:  g.log2_gain = 4'h6;
      ACP_GAIN_512: g.log2_gain = 4'h9;
      default:      g.reserved = 1'b1;
    endcase
    return g;
  endfunction

  //========================================================================
  // Front end decode of the voltage/temperature converter.

  acp_vt_fe_s next_vt_fe;
  acp_gain_s  next_gain;
  logic       ch_reserved;

  // One-hot channel order: battery, external sensor, internal sensor,
  // auxiliary, diagnostic. Reserved codes select no input at all.
  // A case rather than a shift keeps the reserved codes visible.
  always_comb begin
    next_gain                 = decode_gain(f_gain);
    next_vt_fe.enable         = f_en;
    next_vt_fe.power_down     = !f_en;
    next_vt_fe.bypass_neg     = f_bufbp[0];
    next_vt_fe.bypass_pos     = f_bufbp[1];
    next_vt_fe.diag_neg       = f_diag[0];
    next_vt_fe.diag_pos       = f_diag[1];
    next_vt_fe.unipolar       = f_code;
    next_vt_fe.ref_supply     = f_ref;
    next_vt_fe.channel_onehot = 5'h00;
    ch_reserved               = 1'b0;
    unique case (f_ch)
      ACP_CH_BATTERY:  next_vt_fe.channel_onehot = 5'h01;
      ACP_CH_EXT_TEMP: next_vt_fe.channel_onehot = 5'h02;
      ACP_CH_INT_TEMP: next_vt_fe.channel_onehot = 5'h04;
      ACP_CH_AUX:      next_vt_fe.channel_onehot = 5'h08;
      ACP_CH_DIAG:     next_vt_fe.channel_onehot = 5'h10;
      default:         ch_reserved = 1'b1;
    endcase
  end

  // Front end outputs start as an all-zero control word decodes: the
  // converter powered down, battery input, internal reference. Fields
  // are named one by one so a changed reset word shows up here.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vt_fe.enable              <= 1'b0;
      vt_fe.power_down          <= 1'b1;
      vt_fe.bypass_pos          <= 1'b0;
      vt_fe.bypass_neg          <= 1'b0;
      vt_fe.diag_pos            <= 1'b0;
      vt_fe.diag_neg            <= 1'b0;
      vt_fe.unipolar            <= 1'b0;
      vt_fe.channel_onehot      <= 5'h01;
      vt_fe.ref_supply          <= 1'b0;
      current_gain_select       <= '0;
    end else if (pce) begin
      vt_fe                     <= next_vt_fe;
      current_gain_select       <= next_gain;
    end
  end

  //========================================================================
  // Result ready flags.

  logic next_v_rdy;
  logic next_t_rdy;
  logic rd_rdy;

  // A result only counts while the converter runs. Disabling clears both
  // flags and beats a result arriving in the same cycle, since a powered
  // down converter cannot own a fresh result. A read of the ready
  // register clears what it returned; a new result in that cycle wins.
  // Without the enable term a result racing a power down would survive.
  always_comb begin
    rd_rdy     = done && !pwrite && hit_rdy;
    next_v_rdy = voltage_result_ready;
    next_t_rdy = temperature_result_ready;
    if (rd_rdy && prdata[ACP_RDY_V_BIT]) begin
      next_v_rdy = 1'b0;
    end
    if (rd_rdy && prdata[ACP_RDY_T_BIT]) begin
      next_t_rdy = 1'b0;
    end
    if (voltage_conv_done) begin
      next_v_rdy = 1'b1;
    end
    if (temp_conv_done) begin
      next_t_rdy = 1'b1;
    end
    if (!f_en) begin
      next_v_rdy = 1'b0;
      next_t_rdy = 1'b0;
    end
  end

  // Ready flags freeze with the rest of the block while pce is low.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      voltage_result_ready     <= 1'b0;
      temperature_result_ready <= 1'b0;
    end else if (pce) begin
      voltage_result_ready     <= next_v_rdy;
      temperature_result_ready <= next_t_rdy;
    end
  end

  //========================================================================
  // Interrupt events.

  logic [ACP_EV_W-1:0] ev_set;
  logic [ACP_EV_W-1:0] ev_clr;
  logic [ACP_EV_W-1:0] irq_status;

  // Result events count only while enabled. Writing a reserved gain or
  // channel code is flagged so software can catch a bad setting.
  // A bad code is still stored; the flag only tells software to look.
  always_comb begin
    ev_set                = '0;
    ev_set[ACP_EV_VOLT]   = voltage_conv_done && f_en;
    ev_set[ACP_EV_TEMP]   = temp_conv_done && f_en;
    ev_set[ACP_EV_BAD_G]  = wr_cur && next_gain.reserved;
    ev_set[ACP_EV_BAD_CH] = wr_vt && ch_reserved;
    ev_clr                = '0;
    if (done && !pwrite && hit_stat) begin
      ev_clr = prdata[ACP_EV_W-1:0];
    end
  end

  // The bank sees the mask being written, so the interrupt follows a
  // new mask in the same edge that stores it, not one cycle later.
  acp_sticky_bank u_flags (
    .pclk    (pclk),
    .presetn (presetn),
    .pce     (pce),
    .set     (ev_set),
    .clr     (ev_clr),
    .mask    (next_irq_mask),
    .status  (irq_status),
    .irq     (irq)
  );

  //========================================================================
  // Read data and error answer.

  logic [31:0] rd_word;
  logic [31:0] next_prdata;
  logic        next_pslverr;

  // Read data is captured in the setup cycle and held through access.
  // Read clears use this captured word, so a flag raised after capture
  // survives the read and shows on the next one. Capturing early keeps
  // prdata a plain flop output with no read mux behind it.
  always_comb begin
    rd_word = 32'h0000_0000;
    if (hit_vt) begin
      rd_word = vt_ctrl;
    end
    if (hit_cur) begin
      rd_word = cur_ctrl;
    end
    if (hit_rdy) begin
      rd_word[ACP_RDY_V_BIT]  = voltage_result_ready;
      rd_word[ACP_RDY_T_BIT]  = temperature_result_ready;
      rd_word[ACP_RDY_EN_BIT] = vt_ctrl[ACP_EN_BIT];
    end
    if (hit_stat) begin
      rd_word[ACP_EV_W-1:0] = irq_status;
    end
    if (hit_mask) begin
      rd_word[ACP_EV_W-1:0] = irq_mask;
    end
    next_prdata  = prdata;
    next_pslverr = pslverr;
    if (setup) begin
      next_prdata  = pwrite ? 32'h0000_0000 : rd_word;
      next_pslverr = !hit_any;
    end else if (done) begin
      next_pslverr = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (pce) begin
      prdata  <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

endmodule

// >>> testbench/acp_ctrl_regs_chk.sv
// Port checker for the converter control registers, bound to the block.
`timescale 1ns/10ps
module acp_ctrl_regs_chk
  import acp_pkg::*;
(
  input wire logic                pclk,
  input wire logic                presetn,
  input wire logic                pce,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [31:0]         paddr,
  input wire logic [31:0]         pwdata,
  input wire logic                pready,
  input wire acp_pkg::acp_vt_fe_s vt_fe,
  input wire acp_pkg::acp_gain_s  current_gain_select,
  input wire logic                voltage_result_ready,
  input wire logic                temperature_result_ready
);
  //==================================================================
  // Access edges of writes to the two control registers.
  logic wr_vt;
  logic wr_cur;
  assign wr_vt  = psel && penable && pready && pce && pwrite &&
                  paddr == ACP_VT_CTRL_ADDR;
  assign wr_cur = psel && penable && pready && pce && pwrite &&
                  paddr == ACP_CUR_CTRL_ADDR;

  // Expected one-hot channel; reserved codes select no input at all.
  function automatic logic [4:0] ch_oh(input logic [2:0] c);
    ch_oh = (c == 3'h4) ? 5'h08 : (c == 3'h6) ? 5'h10 :
            (c < 3'h3) ? 5'h01 << c : 5'h00;
  endfunction

  // Listed gain codes equal their own exponent, so no table is needed.
  function automatic logic [4:0] gain_exp(input logic [3:0] c);
    gain_exp = (c == 4'h0 || c == 4'h9 || (c >= 4'h2 && c <= 4'h6)) ?
               {c, 1'b0} : 5'h01;
  endfunction

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  //==================================================================
  // Assertions.
  a_ready_cleared: assert property (!vt_fe.enable |->
    !voltage_result_ready && !temperature_result_ready)
    else $error("ready flag set while converter disabled");
  a_power_follows: assert property (
    vt_fe.enable != vt_fe.power_down)
    else $error("power down does not oppose enable");
  a_enable_write: assert property (
    wr_vt |=> vt_fe.enable == $past(pwdata[19]))
    else $error("enable does not follow written bit");
  a_bypass_decode: assert property (
    wr_vt |=> {vt_fe.bypass_pos, vt_fe.bypass_neg} == $past(pwdata[17:16]))
    else $error("buffer bypass decode wrong");
  a_diag_decode: assert property (
    wr_vt |=> {vt_fe.diag_pos, vt_fe.diag_neg} == $past(pwdata[13:12]))
    else $error("diagnostic current decode wrong");
  a_coding_write: assert property (
    wr_vt |=> vt_fe.unipolar == $past(pwdata[9]))
    else $error("result coding wrong");
  a_channel_decode: assert property (
    wr_vt |=> vt_fe.channel_onehot == ch_oh($past(pwdata[8:6])))
    else $error("channel decode wrong");
  a_ref_write: assert property (
    wr_vt |=> vt_fe.ref_supply == $past(pwdata[4]))
    else $error("reference select wrong");
  a_gain_decode: assert property (
    wr_cur |=> current_gain_select == gain_exp($past(pwdata[3:0])))
    else $error("gain decode wrong");
  a_ready_answer: assert property (
    psel && !penable && pce |=> pready ##1 !pready)
    else $error("pready not one cycle after setup");

  // Main scenarios.
  c_enable: cover property (wr_vt && pwdata[19]);
  c_gain_top: cover property (wr_cur && pwdata[3:0] == 4'h9);
  c_ready_drop: cover property ($fell(voltage_result_ready));
endmodule

bind acp_ctrl_regs acp_ctrl_regs_chk u_chk (
  .pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .vt_fe(vt_fe),
  .current_gain_select(current_gain_select),
  .voltage_result_ready(voltage_result_ready),
  .temperature_result_ready(temperature_result_ready)
);

// >>> testbench/adc_control_config_regs_tb_top.sv
// Self-checking bench for the converter control register block.
`timescale 1ns/10ps
module adc_control_config_regs_tb_top;
  import acp_pkg::*;
  logic        pclk, presetn, pce, psel, penable, pwrite;
  logic [31:0] paddr, pwdata, prdata, d;
  logic        pready, pslverr, v_done, t_done, v_rdy, t_rdy, irq;
  acp_vt_fe_s  vt_fe;
  acp_gain_s   gain;
  logic [32:0] exp_q[$];
  int          fails, checks_done, seed, i;

  //==================================================================
  // Clock and device.
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  acp_ctrl_regs u_dut (
    .pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .voltage_conv_done(v_done),
    .temp_conv_done(t_done), .vt_fe(vt_fe),
    .current_gain_select(gain), .voltage_result_ready(v_rdy),
    .temperature_result_ready(t_rdy), .irq(irq)
  );

  //==================================================================
  // Comparison and verdict.
  task automatic check(input string name, input logic [32:0] seen,
                       input logic [32:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // One transfer; the request holds until pready is seen at an edge.
  task automatic apb(input logic w, input logic [31:0] a,
                     input logic [31:0] wd);
    int k;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (pready !== 1'b1) begin
      fails++;
      final_report();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // A read notes its expected {pslverr, prdata} before it starts.
  task automatic rd(input logic [31:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask

  // One-cycle completion pulses from the converters.
  task automatic pulse(input logic v, input logic t);
    @(posedge pclk);
    v_done <= v;
    t_done <= t;
    @(posedge pclk);
    v_done <= 1'b0;
    t_done <= 1'b0;
    @(negedge pclk);
  endtask

  // Read answers are judged mid-cycle, where registered outputs settle.
  always @(negedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      if (exp_q.size() == 0) begin
        check("unexpected read", 33'h0, 33'h1);
      end else begin
        check("read word", {pslverr, prdata}, exp_q.pop_front());
      end
    end
  end

  //==================================================================
  // Main sequence.
  initial begin
    {psel, penable, pwrite, v_done, t_done} = 5'h00;
    paddr = 32'h0;
    pwdata = 32'h0;
    pce = 1'b1;
    presetn = 1'b0;
    fails = 0;
    checks_done = 0;
    seed = 81;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    check("front end", vt_fe, {2'b01, 5'h00, 5'h01, 1'b0});
    rd(ACP_VT_CTRL_ADDR, 33'h0);
    // Every channel code; reserved bits get random ones that must vanish.
    for (i = 0; i < 8; i++) begin
      d = $random(seed);
      d[8:6] = i[2:0];
      d[17:16] = i[1:0];
      d[13:12] = ~i[1:0];
      apb(1'b1, ACP_VT_CTRL_ADDR, d);
      rd(ACP_VT_CTRL_ADDR, {1'b0, d & 32'h000b_33d0});
    end
    // All sixteen gain codes, the reserved ones too.
    for (i = 0; i < 16; i++) begin
      d = i;
      apb(1'b1, ACP_CUR_CTRL_ADDR, d);
    end
    apb(1'b1, ACP_CUR_CTRL_ADDR, 32'hffff_fff9);
    rd(ACP_CUR_CTRL_ADDR, 33'h9);
    // Ready flags set while running and vanish on power down.
    apb(1'b1, ACP_VT_CTRL_ADDR, 32'h0008_0000);
    pulse(1'b1, 1'b1);
    check("ready pair", {v_rdy, t_rdy}, 2'b11);
    rd(ACP_READY_ADDR, 33'h7);
    rd(ACP_READY_ADDR, 33'h4);
    pulse(1'b1, 1'b0);
    apb(1'b1, ACP_VT_CTRL_ADDR, 32'h0003_0000);
    @(negedge pclk);
    check("ready off", {v_rdy, t_rdy}, 2'b00);
    pulse(1'b0, 1'b1);
    rd(ACP_READY_ADDR, 33'h0);
    // Sticky events, masking and clear on read.
    rd(ACP_IRQ_STAT_ADDR, 33'hf);
    @(negedge pclk);
    check("masked irq", irq, 1'b0);
    rd(ACP_IRQ_STAT_ADDR, 33'h0);
    apb(1'b1, ACP_IRQ_MASK_ADDR, 32'h1);
    rd(ACP_IRQ_MASK_ADDR, 33'h1);
    apb(1'b1, ACP_VT_CTRL_ADDR, 32'h0008_0000);
    pulse(1'b0, 1'b1);
    check("irq held low", irq, 1'b0);
    pulse(1'b1, 1'b0);
    check("irq raised", irq, 1'b1);
    rd(ACP_IRQ_STAT_ADDR, 33'h3);
    @(negedge pclk);
    check("irq cleared", irq, 1'b0);
    // An unmapped place answers with an error and keeps nothing.
    apb(1'b1, 32'h4003_0020, 32'hffff_ffff);
    rd(32'h4003_0020, {1'b1, 32'h0});
    rd(ACP_VT_CTRL_ADDR, 33'h0008_0000);
    @(negedge pclk);
    check("notes left", exp_q.size(), 33'h0);
    final_report();
  end
endmodule
